// >>> cpm_pkg.sv
// Shared constants and types of the channel power and mute sequencer.
package cpm_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int NUM_CH = 8;
  localparam logic [7:0] ADDR_VOL_FIRST = 8'h01;
  localparam logic [7:0] ADDR_VOL_LAST = 8'h08;
  localparam logic [7:0] ADDR_CH_PWR = 8'h0D;
  localparam logic [7:0] ADDR_GLOB_PWR = 8'h0E;
  localparam logic [7:0] ADDR_ZC_CFG = 8'h0F;
  localparam logic [7:0] ADDR_STATUS = 8'h1E;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int GLOB_PDN_BIT = 0;
  localparam int ZC_WAIT_BIT = 0;
  localparam int ZC_TSEL_LSB = 1;
  localparam int TSEL_W = 3;
  localparam int ZC_KEEP_BIT = 4;
  localparam int ZC_CFG_W = 5;
  localparam logic [7:0] RST_CH_PWR = 8'h00;
  localparam logic RST_GLOB_PDN = 1'b1;
  localparam logic [4:0] RST_ZC_CFG = 5'h01;
  localparam logic [7:0] RST_VOL = 8'h80;
  localparam logic [7:0] MUTE_VOL = 8'h00;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int NS_PER_MS = 1000000;
  localparam int NS_PER_US = 1000;
  localparam int CYCLES_PER_MS = NS_PER_MS / CLK_PERIOD_NS;
  localparam int SETTLE_US = 100;
  localparam int SETTLE_CYCLES = (SETTLE_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TOUT_MS [8] = '{5, 10, 15, 20, 25, 30, 40, 50};
  localparam int CNT_W = 24;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    CH_OFF,
    CH_RAMP,
    CH_RUN,
    CH_MUTING
  } cpm_ch_state_t;

endpackage

// >>> cpm_zc_apply.sv
// Per-channel zero-crossing gate that decides when a volume change takes effect.
`timescale 1ns/1ns
`default_nettype none
module cpm_zc_apply
  import cpm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] want,
  input wire logic zc,
  input wire logic zc_wait,
  input wire logic keep_prev,
  input wire logic [CNT_W-1:0] tout_limit,
  output logic [7:0] vol,
  output logic pending
);

  logic [7:0] vol_q, vol_d;
  logic [7:0] req_q, req_d;
  logic [7:0] pval_q, pval_d;
  logic pend_q, pend_d;
  logic [CNT_W-1:0] tmr_q, tmr_d;
  logic fire;
  logic new_req;

  assign new_req = (want != req_q);
  assign fire = !zc_wait || zc || (tmr_q >= tout_limit - 24'h000001);

  always_comb begin
    vol_d = vol_q;
    req_d = req_q;
    pval_d = pval_q;
    pend_d = pend_q;
    tmr_d = tmr_q;
    if (pend_q) begin
      tmr_d = tmr_q + 24'h000001;
      if (fire) begin
        vol_d = pval_q;
        pend_d = 1'b0;
      end
    end
    if (new_req) begin
      req_d = want;
      if (!zc_wait) begin
        vol_d = want;
        pend_d = 1'b0;
      end else begin
        if (pend_q && keep_prev) begin
          vol_d = pval_q;
        end
        pval_d = want;
        pend_d = 1'b1;
        tmr_d = '0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      vol_q <= MUTE_VOL;
      req_q <= MUTE_VOL;
      pval_q <= MUTE_VOL;
      pend_q <= 1'b0;
      tmr_q <= '0;
    end else begin
      vol_q <= vol_d;
      req_q <= req_d;
      pval_q <= pval_d;
      pend_q <= pend_d;
      tmr_q <= tmr_d;
    end
  end

  assign vol = vol_q;
  assign pending = pend_q;

  // ****************************************
  // Checks
  // ****************************************
  imm_apply_a: assert property (@(posedge clk) disable iff (rst)
    (!zc_wait && new_req) |=> (vol_q == $past(want) && !pend_q))
    else $error("Immediate change not applied next cycle.");

  tout_apply_a: assert property (@(posedge clk) disable iff (rst)
    (pend_q && tmr_q == tout_limit - 24'h000001 && !new_req) |=>
      (!pend_q && vol_q == $past(pval_q)))
    else $error("Deferred change not applied at time-out.");

  keep_prev_a: assert property (@(posedge clk) disable iff (rst)
    (pend_q && zc_wait && keep_prev && new_req) |=>
      (vol_q == $past(pval_q) && pval_q == $past(want)))
    else $error("Superseded change not applied at once.");

  discard_a: assert property (@(posedge clk) disable iff (rst)
    (pend_q && zc_wait && !keep_prev && !fire && new_req) |=>
      (vol_q == $past(vol_q) && pval_q == $past(want) && pend_q))
    else $error("Superseded change not discarded.");

endmodule
`default_nettype wire

// >>> cpm_sequencer.sv
// Top of the channel power and mute sequencer with its register file.
`timescale 1ns/1ns
`default_nettype none

// Operation
// - Reset held: fully off, accesses ignored.
// - Reset returns every setting to default.
// - Global power-down keeps all amplifiers off.
// - Channel wakes only with both bits clear.
// - Reset: channel bits clear, global bit set.
// - Channel stays muted while amplifier powers up.
// - After power-up, programmed volume is applied.
// - Either bit set powers the channel down.
// - Mute the channel before amplifier power-down.
// - Power mutes follow zero-crossing timing settings.
// - Setting picks immediate or zero-crossing change.
// - Deferred change applies after selectable time-out.
// - Superseded change: apply at once or discard.
module cpm_sequencer
  import cpm_pkg::*;
#(
  parameter int CYCLES_PER_MS_P = CYCLES_PER_MS,
  parameter int SETTLE_CYCLES_P = SETTLE_CYCLES
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [NUM_CH-1:0] zc_in,
  output logic [NUM_CH-1:0] amp_on,
  output logic [NUM_CH-1:0] ch_muted,
  output logic [NUM_CH*8-1:0] ch_vol
);

  // ****************************************
  // Register file
  // ****************************************
  logic [7:0] vol_q [NUM_CH];
  logic [7:0] vol_d [NUM_CH];
  logic [7:0] chpwr_q, chpwr_d;
  logic glob_q, glob_d;
  logic [ZC_CFG_W-1:0] cfg_q, cfg_d;
  logic [7:0] rdata_q, rdata_d;
  logic [2:0] vidx;
  logic vol_hit;

  assign vidx = 3'(reg_addr - ADDR_VOL_FIRST);
  assign vol_hit = (reg_addr >= ADDR_VOL_FIRST) && (reg_addr <= ADDR_VOL_LAST);

  always_comb begin
    vol_d = vol_q;
    chpwr_d = chpwr_q;
    glob_d = glob_q;
    cfg_d = cfg_q;
    rdata_d = rdata_q;
    if (reg_wr) begin
      if (vol_hit) begin
        vol_d[vidx] = reg_wdata;
      end
      if (reg_addr == ADDR_CH_PWR) begin
        chpwr_d = reg_wdata;
      end
      if (reg_addr == ADDR_GLOB_PWR) begin
        glob_d = reg_wdata[GLOB_PDN_BIT];
      end
      if (reg_addr == ADDR_ZC_CFG) begin
        cfg_d = reg_wdata[ZC_CFG_W-1:0];
      end
    end
    if (reg_rd) begin
      rdata_d = 8'h00;
      if (vol_hit) begin
        rdata_d = vol_q[vidx];
      end
      if (reg_addr == ADDR_CH_PWR) begin
        rdata_d = chpwr_q;
      end
      if (reg_addr == ADDR_GLOB_PWR) begin
        rdata_d = {7'h00, glob_q};
      end
      if (reg_addr == ADDR_ZC_CFG) begin
        rdata_d = {3'h0, cfg_q};
      end
      if (reg_addr == ADDR_STATUS) begin
        rdata_d = amp_on;
      end
    end
  end

  // A synchronous reset holds every register, so no access can land while it is high.
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < NUM_CH; i++) begin
        vol_q[i] <= RST_VOL;
      end
      chpwr_q <= RST_CH_PWR;
      glob_q <= RST_GLOB_PDN;
      cfg_q <= RST_ZC_CFG;
      rdata_q <= 8'h00;
    end else begin
      vol_q <= vol_d;
      chpwr_q <= chpwr_d;
      glob_q <= glob_d;
      cfg_q <= cfg_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  wr_take_a: assert property (@(posedge clk) disable iff (rst)
    (reg_wr && reg_addr == ADDR_CH_PWR) |=> (chpwr_q == $past(reg_wdata)))
    else $error("Control write not accepted out of reset.");

  // ****************************************
  // Zero-crossing input synchroniser
  // ****************************************
  // The comparator toggles at each crossing, so any change of level counts as one.
  logic [NUM_CH-1:0] zc_s1_q, zc_s2_q, zc_s3_q;
  logic [NUM_CH-1:0] zc_evt;

  // The chain has no reset, so it follows the pin through reset.
  // A reset to zero would show a false crossing on any pin that idles high.
  always_ff @(posedge clk) begin
    zc_s1_q <= zc_in;
    zc_s2_q <= zc_s1_q;
    zc_s3_q <= zc_s2_q;
  end

  assign zc_evt = zc_s2_q ^ zc_s3_q;

  // ****************************************
  // Time-out selection
  // ****************************************
  logic [TSEL_W-1:0] tsel;
  logic [CNT_W-1:0] tout_limit;
  logic [CNT_W-1:0] settle_limit;

  assign tsel = cfg_q[ZC_TSEL_LSB +: TSEL_W];
  assign tout_limit = CNT_W'(TOUT_MS[tsel] * CYCLES_PER_MS_P);
  assign settle_limit = CNT_W'(SETTLE_CYCLES_P);

  // ****************************************
  // Channel power sequencing
  // ****************************************
  cpm_ch_state_t st_q [NUM_CH];
  cpm_ch_state_t st_d [NUM_CH];
  logic [CNT_W-1:0] cnt_q [NUM_CH];
  logic [CNT_W-1:0] cnt_d [NUM_CH];
  logic [NUM_CH-1:0] pdn;
  logic [NUM_CH-1:0] pend;
  logic [7:0] cur_vol [NUM_CH];
  logic [7:0] want [NUM_CH];

  assign pdn = chpwr_q | {NUM_CH{glob_q}};

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      st_d[i] = st_q[i];
      cnt_d[i] = cnt_q[i];
      unique case (st_q[i])
        CH_OFF: begin
          if (!pdn[i]) begin
            st_d[i] = CH_RAMP;
            cnt_d[i] = '0;
          end
        end
        CH_RAMP: begin
          if (pdn[i]) begin
            st_d[i] = CH_OFF;
          end else if (cnt_q[i] >= settle_limit - 24'h000001) begin
            st_d[i] = CH_RUN;
          end else begin
            cnt_d[i] = cnt_q[i] + 24'h000001;
          end
        end
        CH_RUN: begin
          if (pdn[i]) begin
            st_d[i] = CH_MUTING;
          end
        end
        CH_MUTING: begin
          if (!pdn[i]) begin
            st_d[i] = CH_RUN;
          end else if (!pend[i] && cur_vol[i] == MUTE_VOL) begin
            st_d[i] = CH_OFF;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < NUM_CH; i++) begin
      if (rst) begin
        st_q[i] <= CH_OFF;
        cnt_q[i] <= '0;
      end else begin
        st_q[i] <= st_d[i];
        cnt_q[i] <= cnt_d[i];
      end
    end
  end

  // ****************************************
  // Per-channel volume gates
  // ****************************************
  // Power mutes go through the same gate as user changes, so a slow crossing
  // lengthens power-down; immediate mode avoids that.
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : gen_ch
      assign want[g] = (st_q[g] == CH_RUN) ? vol_q[g] : MUTE_VOL;

      cpm_zc_apply u_zc (
        .clk(clk),
        .rst(rst),
        .want(want[g]),
        .zc(zc_evt[g]),
        .zc_wait(cfg_q[ZC_WAIT_BIT]),
        .keep_prev(cfg_q[ZC_KEEP_BIT]),
        .tout_limit(tout_limit),
        .vol(cur_vol[g]),
        .pending(pend[g])
      );

      assign amp_on[g] = (st_q[g] != CH_OFF);
      assign ch_muted[g] = (st_q[g] != CH_RUN);
      assign ch_vol[g*8 +: 8] = cur_vol[g];

      sequence ramp_done_s;
        st_q[g] == CH_RAMP && !pdn[g] && cnt_q[g] >= settle_limit - 24'h000001;
      endsequence

      sequence run_imm_s;
        st_q[g] == CH_RUN && !cfg_q[ZC_WAIT_BIT] && !pdn[g];
      endsequence

      ramp_mute_a: assert property (@(posedge clk) disable iff (rst)
        (st_q[g] == CH_RAMP) |-> (cur_vol[g] == MUTE_VOL))
        else $error("Channel not muted during power-up.");

      settle_a: assert property (@(posedge clk) disable iff (rst)
        ramp_done_s |=> (st_q[g] == CH_RUN))
        else $error("Settling count did not release the mute.");

      restore_a: assert property (@(posedge clk) disable iff (rst)
        ramp_done_s ##1 run_imm_s |=> (cur_vol[g] == $past(vol_q[g])))
        else $error("Programmed volume not restored after power-up.");

      off_muted_a: assert property (@(posedge clk) disable iff (rst)
        (!amp_on[g]) |-> (cur_vol[g] == MUTE_VOL))
        else $error("Amplifier off while channel not muted.");

      pdn_enter_a: assert property (@(posedge clk) disable iff (rst)
        (st_q[g] == CH_RUN && pdn[g]) |=> (st_q[g] == CH_MUTING))
        else $error("Power-down request not taken.");

      wake_a: assert property (@(posedge clk) disable iff (rst)
        (!amp_on[g] && pdn[g]) |=> !amp_on[g])
        else $error("Channel left power-down with a power-down bit set.");

      wake_go_a: assert property (@(posedge clk) disable iff (rst)
        (st_q[g] == CH_OFF && !pdn[g]) |=> (st_q[g] == CH_RAMP))
        else $error("Channel did not start power-up with both bits clear.");

      ramp_abort_a: assert property (@(posedge clk) disable iff (rst)
        (st_q[g] == CH_RAMP && pdn[g]) |=> (st_q[g] == CH_OFF))
        else $error("Power-down during power-up not taken.");

      mute_first_a: assert property (@(posedge clk) disable iff (rst)
        $fell(amp_on[g]) |-> ($past(cur_vol[g]) == MUTE_VOL))
        else $error("Amplifier powered down before the channel was muted.");

      imm_track_a: assert property (@(posedge clk) disable iff (rst)
        (!cfg_q[ZC_WAIT_BIT]) |=> (cur_vol[g] == $past(want[g])))
        else $error("Immediate mode did not follow the requested volume.");
    end
  endgenerate

  // ****************************************
  // Reset checks
  // ****************************************
  rst_default_a: assert property (@(posedge clk)
    rst |=> (chpwr_q == RST_CH_PWR && glob_q == RST_GLOB_PDN && cfg_q == RST_ZC_CFG))
    else $error("Settings not at default after reset.");

  rst_off_a: assert property (@(posedge clk)
    rst |=> (amp_on == '0 && reg_rdata == 8'h00))
    else $error("Device not fully off under reset.");

  glob_hold_a: assert property (@(posedge clk) disable iff (rst)
    (glob_q && amp_on == '0) |=> (amp_on == '0))
    else $error("Amplifier woke under global power-down.");

endmodule
`default_nettype wire

// >>> cpm_ctrl_model.sv
// System controller model that drives the register port of the sequencer.
`timescale 1ns/1ns
`default_nettype none
module cpm_ctrl_model (
  input wire logic clk,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // ****************************************
  // Access tasks
  // ****************************************
  // Idle address and data lines show the inverse of the last value, so a
  // design that samples them outside a strobe sees garbage, not a copy.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// >>> tb_top.sv
// Self-checking testbench of the channel power and mute sequencer.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
  $display("FAIL %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
  import cpm_pkg::*;
  localparam int CPM = 10;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic [NUM_CH-1:0] zc_in = 8'h00;
  logic [NUM_CH-1:0] amp_on;
  logic [NUM_CH-1:0] ch_muted;
  logic [NUM_CH*8-1:0] ch_vol;
  int err_count = 0;
  int n_compared = 0;

  always #4 clk = ~clk;

  cpm_sequencer #(.CYCLES_PER_MS_P(CPM), .SETTLE_CYCLES_P(4)) dut_u (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .zc_in(zc_in), .amp_on(amp_on),
    .ch_muted(ch_muted), .ch_vol(ch_vol));

  cpm_ctrl_model ctl_u (
    .clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    ctl_u.rd(a, d);
    `CHK("reg_rdata", e, d)
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic zc_flip(input int ch);
    @(posedge clk);
    zc_in[ch] <= ~zc_in[ch];
  endtask

  task automatic tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    wait_n(20000);
    err_count++;
    tally_and_finish();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    logic [63:0] exp_vol;
    logic [7:0] v;
    int tout;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    wait_n(1);
    `CHK("amp_on", 8'h00, amp_on)
    rchk(ADDR_CH_PWR, 8'h00);
    rchk(ADDR_GLOB_PWR, 8'h01);
    rchk(ADDR_ZC_CFG, 8'h01);
    rchk(8'h03, 8'h80);
    rchk(8'h20, 8'h00);
    $display("test reset_defaults done");

    exp_vol = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      ctl_u.wr(ADDR_VOL_FIRST + 8'(i), 8'h10 + 8'(i));
      if (i != 1) exp_vol[8*i +: 8] = 8'h10 + 8'(i);
    end
    ctl_u.wr(ADDR_ZC_CFG, 8'h00);
    ctl_u.wr(ADDR_CH_PWR, 8'h02);
    wait_n(6);
    `CHK("amp_on", 8'h00, amp_on)
    ctl_u.wr(ADDR_GLOB_PWR, 8'h00);
    wait_n(3);
    `CHK("amp_on", 8'hFD, amp_on)
    `CHK("ch_muted", 8'hFF, ch_muted)
    `CHK("ch_vol", 64'h0, ch_vol)
    wait_n(10);
    `CHK("ch_muted", 8'h02, ch_muted)
    `CHK("ch_vol", exp_vol, ch_vol)
    rchk(ADDR_STATUS, 8'hFD);
    $display("test power_up done");

    ctl_u.wr(ADDR_CH_PWR, 8'h03);
    wait_n(8);
    `CHK("amp_on", 8'hFC, amp_on)
    `CHK("ch_vol0", 8'h00, ch_vol[7:0])
    // Wait mode: the power-down mute must sit behind the crossing.
    ctl_u.wr(ADDR_ZC_CFG, 8'h01);
    ctl_u.wr(ADDR_CH_PWR, 8'h07);
    wait_n(10);
    `CHK("amp_on", 8'hFC, amp_on)
    `CHK("ch_vol2", 8'h12, ch_vol[23:16])
    zc_flip(2);
    wait_n(8);
    `CHK("amp_on", 8'hF8, amp_on)
    `CHK("ch_vol2", 8'h00, ch_vol[23:16])
    $display("test power_down done");

    v = 8'h13;
    for (int s = 0; s < 8; s++) begin
      tout = TOUT_MS[s] * CPM;
      ctl_u.wr(ADDR_ZC_CFG, 8'((s << 1) | 1));
      ctl_u.wr(8'h04, 8'h20 + 8'(s));
      wait_n(tout - 6);
      `CHK("ch_vol3", v, ch_vol[31:24])
      wait_n(12);
      v = 8'h20 + 8'(s);
      `CHK("ch_vol3", v, ch_vol[31:24])
    end
    $display("test timeouts done");

    ctl_u.wr(ADDR_ZC_CFG, 8'h00);
    ctl_u.wr(8'h05, 8'h55);
    wait_n(4);
    `CHK("ch_vol4", 8'h55, ch_vol[39:32])
    ctl_u.wr(ADDR_ZC_CFG, 8'h1F);
    ctl_u.wr(8'h05, 8'h11);
    ctl_u.wr(8'h05, 8'h22);
    wait_n(4);
    `CHK("ch_vol4", 8'h11, ch_vol[39:32])
    zc_flip(4);
    wait_n(8);
    `CHK("ch_vol4", 8'h22, ch_vol[39:32])
    ctl_u.wr(ADDR_ZC_CFG, 8'h0F);
    ctl_u.wr(8'h05, 8'h33);
    ctl_u.wr(8'h05, 8'h44);
    wait_n(6);
    `CHK("ch_vol4", 8'h22, ch_vol[39:32])
    zc_flip(4);
    wait_n(8);
    `CHK("ch_vol4", 8'h44, ch_vol[39:32])
    $display("test supersede done");

    // Channel 0 starts its power-up and is sent back down before settling.
    ctl_u.wr(ADDR_CH_PWR, 8'h06);
    ctl_u.wr(ADDR_CH_PWR, 8'h07);
    wait_n(2);
    `CHK("amp_on", 8'hF8, amp_on)
    `CHK("ch_vol0", 8'h00, ch_vol[7:0])
    $display("test ramp_abort done");

    ctl_u.wr(ADDR_ZC_CFG, 8'h00);
    ctl_u.wr(ADDR_GLOB_PWR, 8'h01);
    wait_n(8);
    `CHK("amp_on", 8'h00, amp_on)
    `CHK("ch_vol", 64'h0, ch_vol)
    @(posedge clk);
    rst <= 1'b1;
    ctl_u.wr(ADDR_GLOB_PWR, 8'h00);
    ctl_u.wr(8'h05, 8'h77);
    wait_n(4);
    `CHK("amp_on", 8'h00, amp_on)
    `CHK("ch_muted", 8'hFF, ch_muted)
    @(posedge clk);
    rst <= 1'b0;
    rchk(ADDR_GLOB_PWR, 8'h01);
    rchk(ADDR_CH_PWR, 8'h00);
    rchk(ADDR_ZC_CFG, 8'h01);
    rchk(8'h05, 8'h80);
    $display("test reset_again done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
